// file: hw/bit_fifo.sv
`timescale 1ns/1ns
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    a_fifo_no_overrun : assert property (@(posedge clk) disable iff (!rst_n)
        count_reg <= (AW+1)'(DEPTH))
        else $error("bit fifo count above depth");

endmodule // bit_fifo

// file: hw/sar_adc_defines.svh
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// Result word
`define SAR_BITS        12
`define SAR_LAST_BIT    4'hb
`define SAR_WORD_COUNT  4'hc
`define SAR_MSB_TRIAL   12'h800
`define SAR_CODE_RESET  12'h000

// Falling conversion_clock edges spent sampling before hold
`define SAMPLE_FALLS    2'h2

// Serial bit buffer
`define BIT_FIFO_WIDTH  1
`define BIT_FIFO_DEPTH  8

`endif

// file: hw/sar_adc_pkg.sv
package sar_adc_pkg;

    typedef enum logic [2:0] {
        ST_SHUTDOWN,
        ST_SAMPLE,
        ST_NULL_BIT,
        ST_MSB_OUT,
        ST_LSB_OUT,
        ST_DONE
    } readout_state_t;

endpackage

// file: hw/sar_adc_serial_readout.sv
// Summary of operation
// RULE_01: Select low operates; select high shuts down.
// RULE_02: Each result is a twelve bit word.
// RULE_03: Output enabled at second clock after select.
// RULE_04: A single null bit precedes the result.
// RULE_05: Conversion and shifting paced by conversion_clock only.
// RULE_06: Host clock lies between 10 kHz and 3.2 MHz.
// RULE_07: Result shifted most significant bit first.
// RULE_08: Shifted bits belong to current conversion.
// RULE_09: Extra clocks replay result least significant first.
// RULE_10: Sample at start, then isolate inputs.
// RULE_11: Negative input captured once, at hold.
// RULE_12: First 1.5 to 2 periods sample input.
// RULE_13: After replayed MSB, output floats; clocks ignored.
// RULE_14: New conversion only after select toggles high-low.
// RULE_15: Result code is straight binary.
// RULE_16: Raising select abandons conversion, floats output.
`timescale 1ns/1ns
`include "sar_adc_defines.svh"
module sar_adc_serial_readout (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        select_shutdown_n,
    input  wire logic        conversion_clock,
    input  wire logic        comparator_high,
    output logic             serial_result_out,
    output logic             serial_result_oe_n,
    output logic             powered_up,
    output logic             sample_track,
    output logic             input_hold,
    output logic [11:0]      dac_code,
    output logic [11:0]      result_word,
    output logic             result_strobe
);
    import sar_adc_pkg::*;

    readout_state_t state_reg;
    logic           cc_prev_reg;
    logic           cs_prev_reg;
    logic [1:0]     fall_cnt_reg;
    logic [3:0]     bit_cnt_reg;
    logic [11:0]    shift_reg;
    logic           dout_reg;
    logic           oe_n_reg;
    logic           hold_reg;

    logic           cc_rise;
    logic           cc_fall;
    logic           cs_fall;
    logic           cs_high;
    logic           enter_null;
    logic           pop;
    logic           lsb_step;
    logic           finish;
    logic [3:0]     lsb_idx;

    logic           eng_busy;
    logic           bit_valid;
    logic           bit_ready;
    logic           bit_value;
    logic           fifo_valid;
    logic           fifo_bit;

    // Edges of the host clock; it is far slower than clk
    assign cc_rise = conversion_clock && !cc_prev_reg; // RULE_06
    assign cc_fall = !conversion_clock && cc_prev_reg;
    assign cs_high = select_shutdown_n;
    assign cs_fall = cs_prev_reg && !select_shutdown_n;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cc_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b0;
        end else begin
            cc_prev_reg <= conversion_clock;
            cs_prev_reg <= select_shutdown_n;
        end
    end

    // Sampling ends at the second falling edge after select
    assign enter_null = (state_reg == ST_SAMPLE) && cc_fall
                        && (fall_cnt_reg == `SAMPLE_FALLS - 2'h1); // RULE_12
    assign pop        = cc_fall && fifo_valid
                        && ((state_reg == ST_NULL_BIT)
                        || (state_reg == ST_MSB_OUT && bit_cnt_reg != `SAR_LAST_BIT));
    assign lsb_step   = cc_fall
                        && ((state_reg == ST_MSB_OUT && bit_cnt_reg == `SAR_LAST_BIT)
                        || (state_reg == ST_LSB_OUT && bit_cnt_reg != `SAR_LAST_BIT));
    assign finish     = cc_fall && (state_reg == ST_LSB_OUT)
                        && (bit_cnt_reg == `SAR_LAST_BIT);
    assign lsb_idx    = (state_reg == ST_MSB_OUT) ? 4'h1 : bit_cnt_reg + 4'h1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg    <= ST_SHUTDOWN;
            fall_cnt_reg <= 2'h0;
            bit_cnt_reg  <= 4'h0;
        end else if (cs_high) begin
            state_reg    <= ST_SHUTDOWN; // RULE_16
        end else begin
            unique case (state_reg)
                ST_SHUTDOWN: begin
                    if (cs_fall) begin // RULE_14
                        state_reg    <= ST_SAMPLE;
                        fall_cnt_reg <= 2'h0;
                    end
                end
                ST_SAMPLE: begin
                    if (enter_null) begin
                        state_reg <= ST_NULL_BIT;
                    end else if (cc_fall) begin
                        fall_cnt_reg <= fall_cnt_reg + 2'h1;
                    end
                end
                ST_NULL_BIT: begin
                    if (pop) begin
                        state_reg   <= ST_MSB_OUT;
                        bit_cnt_reg <= 4'h0;
                    end
                end
                ST_MSB_OUT: begin
                    if (lsb_step) begin
                        state_reg   <= ST_LSB_OUT; // RULE_09
                        bit_cnt_reg <= 4'h1;
                    end else if (pop) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                ST_LSB_OUT: begin
                    if (finish) begin
                        state_reg <= ST_DONE; // RULE_13
                    end else if (lsb_step) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_DONE; // RULE_14
                end
                default: begin
                    state_reg <= ST_SHUTDOWN;
                end
            endcase
        end
    end

    // Serial pin driver
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dout_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else if (cs_high || state_reg == ST_SHUTDOWN) begin
            dout_reg <= 1'b0;
            oe_n_reg <= 1'b1; // RULE_01
        end else if (enter_null) begin
            dout_reg <= 1'b0; // RULE_04
            oe_n_reg <= 1'b0; // RULE_03
        end else if (pop) begin
            dout_reg <= fifo_bit; // RULE_07
        end else if (lsb_step || finish) begin
            dout_reg <= finish ? 1'b0 : shift_reg[lsb_idx];
            oe_n_reg <= finish; // RULE_13
        end
    end

    // Copy of the shifted word for the replay
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_reg <= `SAR_CODE_RESET;
        end else if (pop) begin
            shift_reg <= {shift_reg[10:0], fifo_bit}; // RULE_08
        end
    end

    // Both inputs captured together at hold, released at conversion end
    always_ff @(posedge clk) begin
        if (!rst_n || cs_high) begin
            hold_reg <= 1'b0;
        end else if (enter_null) begin
            hold_reg <= 1'b1; // RULE_10
        end else if (hold_reg && !eng_busy && state_reg != ST_NULL_BIT) begin
            hold_reg <= 1'b0; // RULE_11
        end
    end

    sar_engine u_engine (
        .clk             (clk),
        .rst_n           (rst_n),
        .start           (enter_null),
        .abort           (cs_high),
        .step            (cc_rise),
        .comparator_high (comparator_high),
        .dac_code        (dac_code),
        .busy            (eng_busy),
        .bit_valid       (bit_valid),
        .bit_ready       (bit_ready),
        .bit_value       (bit_value),
        .result_word     (result_word),
        .result_strobe   (result_strobe)
    );

    bit_fifo #(
        .WIDTH (`BIT_FIFO_WIDTH),
        .DEPTH (`BIT_FIFO_DEPTH)
    ) u_bits (
        .clk       (clk),
        .rst_n     (rst_n),
        .clear     (cs_high),
        .in_valid  (bit_valid),
        .in_ready  (bit_ready),
        .in_data   (bit_value),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_bit)
    );

    assign serial_result_out  = dout_reg;
    assign serial_result_oe_n = oe_n_reg;
    assign powered_up         = (state_reg != ST_SHUTDOWN); // RULE_01
    assign sample_track       = (state_reg == ST_SAMPLE); // RULE_12
    assign input_hold         = hold_reg;

    // Checking helpers
    logic [1:0] falls_since_cs_reg;
    logic [3:0] pop_cnt_reg;

    always_ff @(posedge clk) begin
        if (!rst_n || cs_fall) begin
            falls_since_cs_reg <= 2'h0;
        end else if (cc_fall && falls_since_cs_reg != 2'h3) begin
            falls_since_cs_reg <= falls_since_cs_reg + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || enter_null) begin
            pop_cnt_reg <= 4'h0;
        end else if (pop) begin
            pop_cnt_reg <= pop_cnt_reg + 4'h1;
        end
    end

    a_shutdown_floats : assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
        select_shutdown_n |=> (state_reg == ST_SHUTDOWN) && serial_result_oe_n && !powered_up)
        else $error("select high did not shut down");

    a_word_length : assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        finish |-> (pop_cnt_reg == `SAR_WORD_COUNT))
        else $error("result word length is not twelve bits");

    a_enable_late : assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        $fell(serial_result_oe_n) |-> (falls_since_cs_reg == 2'h2))
        else $error("output enabled before second clock");

    a_null_first : assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        $fell(serial_result_oe_n) |-> !serial_result_out && state_reg == ST_NULL_BIT)
        else $error("null bit not driven first");

    a_msb_matches : assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
        $rose(state_reg == ST_LSB_OUT) |-> shift_reg == result_word)
        else $error("shifted word differs from the conversion");

    a_bit_not_lost : assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
        bit_valid |-> bit_ready)
        else $error("decided bit found the bit buffer full");

    a_result_in_msb : assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
        result_strobe |-> input_hold && state_reg == ST_MSB_OUT)
        else $error("result completed outside the shifting phase");

    a_dout_on_fall : assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        $changed(serial_result_out) |-> $past(cc_fall) || $past(cs_high)
        || ($past(state_reg) == ST_SHUTDOWN))
        else $error("serial output moved off a falling clock edge");

    a_msb_shift : assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        pop && !select_shutdown_n |=> serial_result_out == $past(fifo_bit))
        else $error("shifted bit differs from the decided bit");

    a_sample_two_falls : assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
        enter_null |-> falls_since_cs_reg == 2'h1)
        else $error("sampling did not last until the second falling edge");

    a_replay_ends : assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
        finish && !select_shutdown_n |=> serial_result_oe_n && state_reg == ST_DONE)
        else $error("output still driven after the replayed top bit");

    a_hold_ends : assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
        $fell(input_hold) |-> !$past(eng_busy) || $past(select_shutdown_n))
        else $error("inputs reconnected during conversion");

    a_lsb_replay : assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
        (state_reg == ST_LSB_OUT) |-> serial_result_out == shift_reg[bit_cnt_reg])
        else $error("replay bit out of order");

    a_done_quiet : assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
        (state_reg == ST_DONE && !select_shutdown_n)
        |=> (state_reg == ST_DONE) && serial_result_oe_n)
        else $error("output active after replay");

    a_restart_toggle : assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
        (state_reg == ST_SAMPLE && $past(state_reg) == ST_SHUTDOWN)
        |-> !$past(select_shutdown_n) && $past(select_shutdown_n, 2))
        else $error("conversion began without select toggle");

    a_hold_after_sample : assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        $rose(input_hold) |-> $past(sample_track) && !sample_track && eng_busy)
        else $error("hold not entered from sampling");

endmodule // sar_adc_serial_readout

// file: hw/sar_engine.sv
`timescale 1ns/1ns
`include "sar_adc_defines.svh"
module sar_engine (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic        step,
    input  wire logic        comparator_high,
    output logic [11:0]      dac_code,
    output logic             busy,
    output logic             bit_valid,
    input  wire logic        bit_ready,
    output logic             bit_value,
    output logic [11:0]      result_word,
    output logic             result_strobe
);
    import sar_adc_pkg::*;

    logic [11:0] dac_code_reg;
    logic [11:0] mask_reg;
    logic        busy_reg;
    logic [11:0] result_reg;
    logic        strobe_reg;
    logic [11:0] code_next;
    logic        decide;

    // One bit is decided per rising conversion_clock edge
    assign decide    = busy_reg && step && bit_ready;
    assign bit_valid = busy_reg && step;
    assign bit_value = comparator_high;
    // Straight binary: a set bit keeps its trial weight
    assign code_next = (dac_code_reg & ~mask_reg) | (comparator_high ? mask_reg : 12'h000);

    always_ff @(posedge clk) begin
        if (!rst_n || abort) begin
            busy_reg     <= 1'b0;
            mask_reg     <= 12'h000;
            dac_code_reg <= `SAR_CODE_RESET;
        end else if (start) begin
            busy_reg     <= 1'b1;
            mask_reg     <= `SAR_MSB_TRIAL;
            dac_code_reg <= `SAR_MSB_TRIAL;
        end else if (decide) begin // RULE_05
            mask_reg     <= mask_reg >> 1;
            dac_code_reg <= code_next | (mask_reg >> 1); // RULE_15
            if (mask_reg[0]) begin
                busy_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_reg <= `SAR_CODE_RESET;
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= decide && mask_reg[0] && !abort;
            if (decide && mask_reg[0] && !abort) begin
                result_reg <= code_next;
            end
        end
    end

    assign dac_code      = dac_code_reg;
    assign busy          = busy_reg;
    assign result_word   = result_reg;
    assign result_strobe = strobe_reg;

    a_code_paced : assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        $changed(dac_code_reg) |-> $past(start) || $past(decide) || $past(abort))
        else $error("trial code moved without a conversion clock step");

endmodule // sar_engine

// file: testbench/host_model.sv
`timescale 1ns/1ns
module host_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [5:0]  nfalls,
    input  wire logic [7:0]  half,
    input  wire logic        keep_high,
    input  wire logic        serial_result_out,
    input  wire logic        serial_result_oe_n,
    output logic             select_shutdown_n,
    output logic             conversion_clock,
    output logic             busy,
    output logic [31:0]      cap_dout,
    output logic [31:0]      cap_oe_n
);
    task automatic wait_half();
        repeat (half) @(posedge clk);
        #2;
    endtask

    task automatic grab(input int k);
        cap_dout[k] = serial_result_out;
        cap_oe_n[k] = serial_result_oe_n;
    endtask

    initial begin
        select_shutdown_n = 1'b1;
        conversion_clock  = 1'b0;
        busy              = 1'b0;
        cap_dout          = '0;
        cap_oe_n          = '1;
        forever begin
            @(posedge clk);
            if (go === 1'b1) begin
                #2;
                busy = 1'b1;
                cap_oe_n = '1;
                select_shutdown_n = keep_high;
                wait_half();
                grab(0);
                for (int i = 1; i <= nfalls; i++) begin
                    conversion_clock = 1'b1;
                    wait_half();
                    conversion_clock = 1'b0;
                    wait_half();
                    grab(i);
                end
                select_shutdown_n = 1'b1;
                repeat (4) @(posedge clk);
                #2;
                grab(31);
                busy = 1'b0;
            end
        end
    end
endmodule // host_model

// file: testbench/tb_sar_adc_serial_readout.sv
`timescale 1ns/1ns
module tb_sar_adc_serial_readout;
    logic        clk;
    logic        rst_n;
    logic        select_shutdown_n;
    logic        conversion_clock;
    logic        comparator_high;
    logic        serial_result_out;
    logic        serial_result_oe_n;
    logic        powered_up;
    logic        sample_track;
    logic        input_hold;
    logic [11:0] dac_code;
    logic [11:0] result_word;
    logic        result_strobe;
    logic        go;
    logic [5:0]  nfalls;
    logic [7:0]  half;
    logic        keep_high;
    logic        busy;
    logic [31:0] cap_dout;
    logic [31:0] cap_oe_n;
    logic [11:0] tgt;
    logic [11:0] res_q[$];
    logic [15:0] seed;
    int          err_total;
    int          total_checks;
    int          cycles;

    sar_adc_serial_readout dut (
        .clk(clk), .rst_n(rst_n), .select_shutdown_n(select_shutdown_n),
        .conversion_clock(conversion_clock), .comparator_high(comparator_high),
        .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
        .powered_up(powered_up), .sample_track(sample_track), .input_hold(input_hold),
        .dac_code(dac_code), .result_word(result_word), .result_strobe(result_strobe)
    );

    host_model host (
        .clk(clk), .go(go), .nfalls(nfalls), .half(half), .keep_high(keep_high),
        .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
        .select_shutdown_n(select_shutdown_n), .conversion_clock(conversion_clock),
        .busy(busy), .cap_dout(cap_dout), .cap_oe_n(cap_oe_n)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Comparator: input at or above the trial code
    always @(posedge clk) begin
        #2;
        comparator_high = (tgt >= dac_code);
    end

    always @(posedge clk) begin
        if (rst_n === 1'b1 && result_strobe === 1'b1) begin
            res_q.push_back(result_word);
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            complete_run();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic exp_bit(input logic [11:0] code, input int k);
        if (k == 2) begin
            return 1'b0;
        end
        return (k <= 14) ? code[14-k] : code[k-14];
    endfunction

    task automatic check_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_word(input string name, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic run_conv(input logic [11:0] code, input int nf, input int hp, input logic kh);
        int   k;
        int   cnt;
        logic ex;
        @(posedge clk);
        #2;
        tgt = code;
        nfalls = nf[5:0];
        half = hp[7:0];
        keep_high = kh;
        res_q.delete();
        go = 1'b1;
        @(posedge clk);
        #2;
        go = 1'b0;
        cnt = 0;
        do begin
            @(posedge clk);
            cnt++;
            if (cnt == 4) begin
                check_bit("powered_up", !kh, powered_up);
                check_bit("sample_track", !kh, sample_track);
                check_bit("hold_in_sample", 1'b0, input_hold);
                check_word("dac_code_idle", 12'h000, dac_code);
            end
        end while (busy === 1'b1 && cnt < 5000);
        if (cnt >= 5000) begin
            err_total++;
            complete_run();
        end
        for (k = 0; k <= nf; k++) begin
            ex = (kh || k < 2 || k > 25);
            check_bit("oe_n", ex, cap_oe_n[k]);
            if (!ex) begin
                check_bit("dout", exp_bit(code, k), cap_dout[k]);
            end
        end
        check_bit("oe_n_after_deselect", 1'b1, cap_oe_n[31]);
        check_bit("input_hold", 1'b0, input_hold);
        check_bit("powered_up_idle", 1'b0, powered_up);
        check_bit("one_result", (nf >= 14 && !kh), res_q.size() == 1);
        if (res_q.size() == 1) begin
            check_word("result_word", code, res_q[0]);
        end
    endtask

    initial begin
        logic [11:0] codes [4];
        codes = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
        rst_n = 1'b0;
        go = 1'b0;
        nfalls = 6'h1a;
        half = 8'h08;
        keep_high = 1'b0;
        tgt = 12'h000;
        comparator_high = 1'b0;
        err_total = 0;
        total_checks = 0;
        cycles = 0;
        seed = 16'hf9e7;
        repeat (12) @(posedge clk);
        #2;
        rst_n = 1'b1;
        foreach (codes[i]) begin
            run_conv(codes[i], 26, 8, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            run_conv(seed[11:0], 28, (i % 2) ? 40 : 8, 1'b0);
        end
        run_conv(12'ha5c, 8, 8, 1'b0);
        run_conv(12'h3c3, 28, 8, 1'b1);
        run_conv(12'h5a5, 26, 8, 1'b0);
        complete_run();
    end
endmodule // tb_sar_adc_serial_readout
